// ---- hdl/cpm_hold.sv ----
// Hold (DMA) bus handover logic of the processor module with APB control
//
// Operation
// - Hold request sampled only in wait or stopped, by gated 400 kHz pulse.
// - Sampling pulse with hold request present sets hold and drives acknowledge.
// - During hold, float data, I/O strobes, write strobe and address but for bits fourteen, fifteen; disable decoder.
// - Requester may drop hold request after acknowledge; hold persists.
// - Hold lasts until wait request released or interrupt received.
// - Wait release edge presets hold latch, ending hold and acknowledge.
// - Registered interrupt presets hold latch, dropping acknowledge at once.
// - Write strobe active low by default; option makes it active high.
// - Address bits fourteen, fifteen low by default; option routes cycle code.
// - Separate indicators for fetch, I/O, read, write and interrupt cycles.
// - Flags on status outputs, plus four data bits captured in fourth state.
//
// The APB register port and the address map were decided locally.
module cpm_hold
	import cpm_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Pins from external requesters
	input  wire logic        wait_req_n_in,
	input  wire logic        hold_req_in,
	input  wire logic        int_req_in,
	input  wire logic        bus_busy_n_in,
	// Processor core side, same clock
	input  wire logic [2:0]  proc_state_in,
	input  wire logic [1:0]  cycle_type_code_in,
	input  wire logic [13:0] core_addr_in,
	input  wire logic [7:0]  core_data_in,
	input  wire cpm_flags_t  core_flags_in,
	input  wire logic        phase_sync_timing_in,
	// Module outputs
	output logic             hold_ack_out,
	output logic             int_latch_out,
	output logic [13:0]      addr_out,
	output logic             address_bit_fourteen_out,
	output logic             address_bit_fifteen_out,
	output logic             addr_oe_n_out,
	output logic [7:0]       data_out,
	output logic             data_oe_n_out,
	output logic             io_in_n_out,
	output logic             io_in_oe_n_out,
	output logic             io_out_n_out,
	output logic             io_out_oe_n_out,
	output logic             wr_strobe_out,
	output logic             wr_oe_n_out,
	output cpm_cycles_t      cycles_out,
	output logic             sign_flag_out,
	output logic             zero_flag_out,
	output logic             parity_flag_out,
	output logic             carry_flag_out,
	output logic [3:0]       t4_data_out
);

	// Pin synchronisers: meta stage, sync stage, delayed copy for edges
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic [3:0] pin_prev;
	logic       wait_n_s;
	logic       hold_req_s;
	logic       int_req_s;
	logic       busy_n_s;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_meta <= 4'h9; // Idle levels: busy and wait released, no requests
			pin_sync <= 4'h9;
			pin_prev <= 4'h9;
		end else begin
			pin_meta <= {bus_busy_n_in, int_req_in, hold_req_in, wait_req_n_in};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	assign wait_n_s   = pin_sync[0];
	assign hold_req_s = pin_sync[1];
	assign int_req_s  = pin_sync[2];
	assign busy_n_s   = pin_sync[3];

	// State decode helpers
	function automatic logic is_state(input logic [2:0] st, input logic [2:0] code);
		return st == code;
	endfunction

	function automatic logic is_cycle(input logic [1:0] cc, input logic [1:0] code);
		return cc == code;
	endfunction

	logic wait_or_stop;
	assign wait_or_stop = is_state(proc_state_in, CPM_ST_WAIT)
	                    | is_state(proc_state_in, CPM_ST_STOPPED);

	// Free-running divider giving one pulse every 400 kHz period
	logic [7:0] sample_cnt;
	logic       sample_pulse;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sample_cnt <= 8'h00;
		end else if (sample_cnt == CPM_SAMPLE_LAST) begin
			sample_cnt <= 8'h00;
		end else begin
			sample_cnt <= sample_cnt + 8'h01;
		end
	end

	assign sample_pulse = (sample_cnt == CPM_SAMPLE_LAST) & wait_or_stop;

	// Interrupt request latch, then interrupt latch on the phase sync pulse
	logic int_req_latch;
	logic int_latch;
	logic int_latch_d;
	logic int_cycle;
	logic int_rise;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			int_req_latch <= 1'b0;
		end else if (int_req_s & ~pin_prev[2]) begin
			int_req_latch <= 1'b1; // New request wins over acknowledge
		end else if (is_state(proc_state_in, CPM_ST_T1I)) begin
			int_req_latch <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			int_latch   <= 1'b0;
			int_latch_d <= 1'b0;
		end else begin
			if (phase_sync_timing_in) begin
				int_latch <= int_req_latch;
			end
			int_latch_d <= int_latch;
		end
	end

	assign int_rise      = int_latch & ~int_latch_d;
	assign int_latch_out = int_latch;

	// Interrupt cycle latch: set in T1I, reset in T1 or stopped
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			int_cycle <= 1'b0;
		end else if (is_state(proc_state_in, CPM_ST_T1I)) begin
			int_cycle <= 1'b1;
		end else if (is_state(proc_state_in, CPM_ST_T1)
		          | is_state(proc_state_in, CPM_ST_STOPPED)) begin
			int_cycle <= 1'b0;
		end
	end

	// Hold handover state machine
	cpm_hold_t hold_st;
	cpm_hold_t next_hold_st;
	logic      wait_release;
	logic      hold_end;
	logic      floating;

	assign wait_release = wait_n_s & ~pin_prev[0];
	assign hold_end     = wait_release | int_rise;

	always_comb begin
		next_hold_st = hold_st;
		case (hold_st)
			CPM_HOLD_IDLE: begin
				if (sample_pulse & hold_req_s & ~hold_end) begin
					next_hold_st = CPM_HOLD_ACTIVE;
				end
			end
			CPM_HOLD_ACTIVE: begin
				if (hold_end) begin
					next_hold_st = CPM_HOLD_RELEASE;
				end
			end
			CPM_HOLD_RELEASE: begin
				next_hold_st = CPM_HOLD_IDLE;
			end
			default: begin
				next_hold_st = CPM_HOLD_IDLE;
			end
		endcase
	end

	// Hold request is not looked at while active, so it may be withdrawn
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			hold_st <= CPM_HOLD_IDLE;
		end else begin
			hold_st <= next_hold_st;
		end
	end

	// Preset drops the acknowledge in the same cycle as the end event
	assign hold_ack_out = (hold_st == CPM_HOLD_ACTIVE) & ~hold_end;
	assign floating     = hold_st != CPM_HOLD_IDLE;

	// Control register
	cpm_ctrl_t ctrl;
	logic      apb_setup;
	logic      apb_access;
	logic      addr_ok;

	assign apb_setup  = psel_in & ~penable_in;
	assign apb_access = psel_in & penable_in;
	assign addr_ok    = (paddr_in == CPM_CTRL_ADDR) | (paddr_in == CPM_STATUS_ADDR);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl <= cpm_ctrl_t'(CPM_CTRL_RESET[1:0]);
		end else if (apb_access & pwrite_in & (paddr_in == CPM_CTRL_ADDR)) begin
			ctrl.wr_invert     <= pwdata_in[CPM_CTRL_WR_INV_BIT];
			ctrl.addr_hi_route <= pwdata_in[CPM_CTRL_ADDR_HI_BIT];
		end
	end

	// Read data captured in the setup cycle, answered in the access cycle
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (paddr_in == CPM_CTRL_ADDR) begin
			next_rdata[CPM_CTRL_WR_INV_BIT]  = ctrl.wr_invert;
			next_rdata[CPM_CTRL_ADDR_HI_BIT] = ctrl.addr_hi_route;
		end else if (paddr_in == CPM_STATUS_ADDR) begin
			next_rdata[CPM_STAT_HOLD_ACK_BIT] = hold_ack_out;
			next_rdata[CPM_STAT_FLOAT_BIT]    = floating;
			next_rdata[CPM_STAT_INT_LTH_BIT]  = int_latch;
			next_rdata[CPM_STAT_BUSY_BIT]     = ~busy_n_s;
			next_rdata[CPM_STAT_WAIT_BIT]     = ~wait_n_s;
			next_rdata[CPM_STAT_HOLD_REQ_BIT] = hold_req_s;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (apb_setup & ~pwrite_in) begin
			prdata_out <= next_rdata;
		end
	end

	assign pready_out  = apb_access;
	assign pslverr_out = apb_access & ~addr_ok;

	// Cycle decoder and bus drivers; decoder disabled while floating
	logic t3;
	logic io_out_dir;
	logic wr_active;

	assign t3         = is_state(proc_state_in, CPM_ST_T3);
	assign io_out_dir = core_addr_in[13] | core_addr_in[12];
	assign wr_active  = is_cycle(cycle_type_code_in, CPM_CC_WRITE) & t3;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cycles_out               <= '0;
			addr_out                 <= 14'h0000;
			address_bit_fourteen_out <= 1'b0;
			address_bit_fifteen_out  <= 1'b0;
			data_out                 <= 8'h00;
			io_in_n_out              <= 1'b1;
			io_out_n_out             <= 1'b1;
			wr_strobe_out            <= 1'b1;
		end else begin
			cycles_out.fetch     <= ~floating & is_cycle(cycle_type_code_in, CPM_CC_FETCH);
			cycles_out.io        <= ~floating & is_cycle(cycle_type_code_in, CPM_CC_IO);
			cycles_out.mem_read  <= ~floating & is_cycle(cycle_type_code_in, CPM_CC_READ);
			cycles_out.mem_write <= ~floating & is_cycle(cycle_type_code_in, CPM_CC_WRITE);
			cycles_out.intr      <= ~floating & int_cycle;
			addr_out             <= core_addr_in;
			address_bit_fourteen_out <= ctrl.addr_hi_route & cycle_type_code_in[0];
			address_bit_fifteen_out  <= ctrl.addr_hi_route & cycle_type_code_in[1];
			data_out             <= core_data_in;
			io_in_n_out  <= ~(is_cycle(cycle_type_code_in, CPM_CC_IO) & t3 & ~io_out_dir);
			io_out_n_out <= ~(is_cycle(cycle_type_code_in, CPM_CC_IO) & t3 & io_out_dir);
			wr_strobe_out <= ctrl.wr_invert ? wr_active : ~wr_active;
		end
	end

	// Output enables, low while driving; high from the hold until after release
	assign addr_oe_n_out   = floating;
	assign data_oe_n_out   = floating;
	assign io_in_oe_n_out  = floating;
	assign io_out_oe_n_out = floating;
	assign wr_oe_n_out     = floating;

	// Flags and fourth-state data
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sign_flag_out   <= 1'b0;
			zero_flag_out   <= 1'b0;
			parity_flag_out <= 1'b0;
			carry_flag_out  <= 1'b0;
			t4_data_out     <= 4'h0;
		end else begin
			sign_flag_out   <= core_flags_in.sign;
			zero_flag_out   <= core_flags_in.zero;
			parity_flag_out <= core_flags_in.parity;
			carry_flag_out  <= core_flags_in.carry;
			if (is_state(proc_state_in, CPM_ST_T4)) begin
				t4_data_out <= core_data_in[7:4];
			end
		end
	end

	// Checks on the handover behaviour
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	chk_sample_gate: assert property (
		(hold_st == CPM_HOLD_IDLE) ##1 (hold_st == CPM_HOLD_ACTIVE)
		|-> $past(sample_pulse & hold_req_s & wait_or_stop))
		else $error("hold taken outside gated sample");

	chk_ack_on_sample: assert property (
		(hold_st == CPM_HOLD_IDLE && sample_pulse && hold_req_s && !hold_end)
		|=> hold_ack_out || (hold_st == CPM_HOLD_ACTIVE && hold_end))
		else $error("sample with request did not acknowledge");

	chk_float_all: assert property (
		hold_ack_out |-> addr_oe_n_out && data_oe_n_out && io_in_oe_n_out
		&& io_out_oe_n_out && wr_oe_n_out ##1 (cycles_out == '0))
		else $error("outputs not floated during hold");

	chk_hold_keeps: assert property (
		(hold_st == CPM_HOLD_ACTIVE && !hold_end && !hold_req_s)
		|=> hold_st == CPM_HOLD_ACTIVE)
		else $error("hold dropped with request withdrawn");

	chk_wait_end: assert property (
		(hold_st == CPM_HOLD_ACTIVE && wait_release)
		|-> !hold_ack_out ##1 hold_st == CPM_HOLD_RELEASE ##1 hold_st == CPM_HOLD_IDLE)
		else $error("wait release did not end hold");

	chk_int_preset: assert property (
		$rose(int_latch) |-> !hold_ack_out)
		else $error("interrupt did not drop acknowledge");

	chk_wr_polarity: assert property (
		$past(!wr_active) |-> wr_strobe_out == !$past(ctrl.wr_invert))
		else $error("idle write strobe level wrong");

	chk_addr_high: assert property (
		!$past(ctrl.addr_hi_route) |-> !address_bit_fourteen_out && !address_bit_fifteen_out)
		else $error("high address bits not low by default");

	chk_t4_capture: assert property (
		is_state(proc_state_in, CPM_ST_T4) |=> t4_data_out == $past(core_data_in[7:4]))
		else $error("fourth state data not captured");

	chk_drive_return: assert property (
		$fell(hold_ack_out) |-> addr_oe_n_out ##1 addr_oe_n_out)
		else $error("drive returned before hold released");

	cov_hold_taken: cover property (hold_st == CPM_HOLD_IDLE ##1 hold_st == CPM_HOLD_ACTIVE);
	cov_wait_end:   cover property (hold_st == CPM_HOLD_ACTIVE && wait_release);
	cov_int_end:    cover property (hold_st == CPM_HOLD_ACTIVE && int_rise);
	cov_ctrl_write: cover property (apb_access && pwrite_in && paddr_in == CPM_CTRL_ADDR);

endmodule

// ---- hdl/cpm_pkg.sv ----
// Constants, processor codes and carrier types of the hold handover block
package cpm_pkg;

	// Register map, byte addresses on a 32-bit APB
	localparam logic [11:0] CPM_CTRL_ADDR   = 12'h000;
	localparam logic [11:0] CPM_STATUS_ADDR = 12'h004;
	localparam logic [31:0] CPM_CTRL_RESET  = 32'h0000_0000;

	// Control field positions
	localparam int CPM_CTRL_WR_INV_BIT   = 0;
	localparam int CPM_CTRL_ADDR_HI_BIT  = 1;

	// Status field positions
	localparam int CPM_STAT_HOLD_ACK_BIT = 0;
	localparam int CPM_STAT_FLOAT_BIT    = 1;
	localparam int CPM_STAT_INT_LTH_BIT  = 2;
	localparam int CPM_STAT_BUSY_BIT     = 3;
	localparam int CPM_STAT_WAIT_BIT     = 4;
	localparam int CPM_STAT_HOLD_REQ_BIT = 5;

	// Hold sampling pulse timing
	localparam int CPM_CLK_HZ         = 100_000_000;
	localparam int CPM_SAMPLE_HZ      = 400_000;
	localparam int CPM_SAMPLE_CYCLES  = CPM_CLK_HZ / CPM_SAMPLE_HZ;
	localparam logic [7:0] CPM_SAMPLE_LAST = 8'(CPM_SAMPLE_CYCLES - 1);

	// Processor state codes seen on the state lines
	localparam logic [2:0] CPM_ST_T1      = 3'h2;
	localparam logic [2:0] CPM_ST_T1I     = 3'h6;
	localparam logic [2:0] CPM_ST_T2      = 3'h4;
	localparam logic [2:0] CPM_ST_WAIT    = 3'h0;
	localparam logic [2:0] CPM_ST_T3      = 3'h1;
	localparam logic [2:0] CPM_ST_STOPPED = 3'h3;
	localparam logic [2:0] CPM_ST_T4      = 3'h7;
	localparam logic [2:0] CPM_ST_T5      = 3'h5;

	// Cycle type codes
	localparam logic [1:0] CPM_CC_FETCH = 2'h0;
	localparam logic [1:0] CPM_CC_READ  = 2'h2;
	localparam logic [1:0] CPM_CC_IO    = 2'h1;
	localparam logic [1:0] CPM_CC_WRITE = 2'h3;

	// Hold handover states, Gray coded along idle, active, release
	typedef enum logic [1:0] {
		CPM_HOLD_IDLE    = 2'b00,
		CPM_HOLD_ACTIVE  = 2'b01,
		CPM_HOLD_RELEASE = 2'b11
	} cpm_hold_t;

	// Software options
	typedef struct packed {
		logic addr_hi_route;
		logic wr_invert;
	} cpm_ctrl_t;

	// Cycle type indicators
	typedef struct packed {
		logic fetch;
		logic io;
		logic mem_read;
		logic mem_write;
		logic intr;
	} cpm_cycles_t;

	// Condition flags
	typedef struct packed {
		logic sign;
		logic zero;
		logic parity;
		logic carry;
	} cpm_flags_t;

endpackage

// ---- tb/cpm_dma_model.sv ----
// Behavioural DMA device controller on the far side of the hold handover pins
module cpm_dma_model (
	input  wire logic clk_in,
	input  wire logic nrst_in,
	input  wire logic start_in,
	input  wire logic finish_in,
	input  wire logic hold_ack_in,
	output logic      wait_req_n_out,
	output logic      hold_req_out,
	output logic      bus_busy_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic clamp;

	// Open collector line with pull-up: high unless this controller clamps it
	assign bus_busy_n_out = clamp ? 1'b0 : 1'b1;

	// Request sequence: wait first, then hold and clamp, hold dropped on acknowledge
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wait_req_n_out <= 1'b1;
			hold_req_out   <= 1'b0;
			clamp          <= 1'b0;
		end else begin
			if (start_in && bus_busy_n_out && wait_req_n_out)
				wait_req_n_out <= 1'b0;
			if (!wait_req_n_out && !clamp && !finish_in) begin
				clamp        <= 1'b1;
				hold_req_out <= 1'b1;
			end
			if (hold_ack_in)
				hold_req_out <= 1'b0;
			if (finish_in) begin
				wait_req_n_out <= 1'b1;
				clamp          <= 1'b0;
				hold_req_out   <= 1'b0;
			end
		end
	end
endmodule

// ---- tb/tb_cpu_module_dma_hold_handover.sv ----
// Self-checking bench of the hold handover block
module tb_cpu_module_dma_hold_handover
	import cpm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic start = 0, finish = 0, wait_n, hold_req, busy_n, int_req = 0, psync = 0;
	logic [2:0] st = CPM_ST_T1;
	logic [1:0] cc = CPM_CC_READ;
	logic [13:0] caddr = 14'h0123;
	logic [7:0] cdata = 8'h00, dout;
	cpm_flags_t flags = '0;
	cpm_cycles_t cyc;
	logic ack, intl, a14, a15, aoe, doe, ion, iioe, ioon, iooe, wrs, wroe, sf, zf, pf, cf, err;
	logic [13:0] aout;
	logic [3:0] t4d;
	int errors = 0, n_compared = 0;

	always #5 clk = ~clk;

	cpm_dma_model peer (.clk_in(clk), .nrst_in(nrst), .start_in(start), .finish_in(finish),
		.hold_ack_in(ack), .wait_req_n_out(wait_n), .hold_req_out(hold_req),
		.bus_busy_n_out(busy_n));

	cpm_hold dut (.clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .wait_req_n_in(wait_n),
		.hold_req_in(hold_req), .int_req_in(int_req), .bus_busy_n_in(busy_n),
		.proc_state_in(st), .cycle_type_code_in(cc), .core_addr_in(caddr),
		.core_data_in(cdata), .core_flags_in(flags), .phase_sync_timing_in(psync),
		.hold_ack_out(ack), .int_latch_out(intl), .addr_out(aout),
		.address_bit_fourteen_out(a14), .address_bit_fifteen_out(a15),
		.addr_oe_n_out(aoe), .data_out(dout), .data_oe_n_out(doe), .io_in_n_out(ion),
		.io_in_oe_n_out(iioe), .io_out_n_out(ioon), .io_out_oe_n_out(iooe),
		.wr_strobe_out(wrs), .wr_oe_n_out(wroe), .cycles_out(cyc), .sign_flag_out(sf),
		.zero_flag_out(zf), .parity_flag_out(pf), .carry_flag_out(cf), .t4_data_out(t4d));

	task conclude;
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer held until pready is sampled high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
		if (pready !== 1'b1) begin
			errors++;
			$display("[ERR] %0t bus timeout", $time);
			conclude;
		end
	endtask

	// Bounded wait for the acknowledge level, sampled on the falling edge
	task wait_ack(input logic lvl, input int lim);
		int n;
		n = 0;
		while (ack !== lvl && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (ack !== lvl) begin
			errors++;
			$display("[ERR] %0t acknowledge wait timeout", $time);
			conclude;
		end
	endtask

	// One-cycle strobes on the bench's own signals
	task pulse_finish;
		@(posedge clk) finish <= 1;
		@(posedge clk) finish <= 0;
	endtask

	task pulse_psync;
		@(posedge clk) psync <= 1;
		@(posedge clk) psync <= 0;
	endtask

	// Register reset value, access and unmapped refusal
	task t_regs;
		apb(0, CPM_CTRL_ADDR, 0); chk(rd, CPM_CTRL_RESET);
		apb(0, 12'h008, 0); chk(err, 1);
		apb(1, CPM_STATUS_ADDR, 32'hffff_ffff); chk(err, 0);
	endtask

	// Write strobe polarity and upper address bits, both option settings
	task t_opts;
		for (int i = 0; i < 2; i++) begin
			apb(1, CPM_CTRL_ADDR, i ? 32'h3 : 32'h0);
			@(posedge clk) st <= CPM_ST_T2; cc <= CPM_CC_WRITE;
			repeat (4) @(negedge clk);
			chk(wrs, i ? 0 : 1);
			chk({a15, a14}, i ? 2'b11 : 2'b00);
			@(posedge clk) st <= CPM_ST_T3;
			repeat (2) @(negedge clk);
			chk(wrs, i ? 1 : 0);
			@(posedge clk) cc <= CPM_CC_IO;
			repeat (2) @(negedge clk);
			chk({a15, a14}, i ? 2'b01 : 2'b00);
		end
		apb(1, CPM_CTRL_ADDR, 0);
	endtask

	// Status flags and data captured in the fourth state
	task t_flags;
		@(posedge clk) flags <= 4'b1010; st <= CPM_ST_T4; cdata <= 8'hc3;
		@(posedge clk) st <= CPM_ST_T5;
		repeat (2) @(negedge clk);
		chk({sf, zf, pf, cf}, 4'b1010);
		chk(t4d, 4'hc);
	endtask

	// Cycle indicators, I/O strobes and bus copies while driving
	task t_cycles;
		@(posedge clk) st <= CPM_ST_T3; cc <= CPM_CC_IO; caddr <= 14'h0105; cdata <= 8'h5a;
		repeat (2) @(negedge clk);
		chk(cyc, 5'b01000);
		chk({ion, ioon}, 2'b01);
		chk(aout, 14'h0105);
		chk(dout, 8'h5a);
		@(posedge clk) caddr <= 14'h1105;
		repeat (2) @(negedge clk);
		chk({ion, ioon}, 2'b10);
		@(posedge clk) st <= CPM_ST_T1I; cc <= CPM_CC_FETCH;
		repeat (3) @(negedge clk);
		chk(cyc, 5'b10001);
		@(posedge clk) st <= CPM_ST_T1; cc <= CPM_CC_READ;
		repeat (3) @(negedge clk);
		chk(cyc, 5'b00100);
	endtask

	// Request outside wait or stopped is ignored
	task t_refuse;
		int seen;
		seen = 0;
		@(posedge clk) st <= CPM_ST_T3; start <= 1;
		repeat (600) begin
			@(negedge clk);
			seen += (ack === 1'b1);
		end
		chk(seen, 0);
		pulse_finish;
		start <= 0;
	endtask

	// Hold in wait state, request withdrawn, ended by wait release
	task t_hold_wait;
		@(posedge clk) st <= CPM_ST_WAIT; start <= 1;
		wait_ack(1, 600);
		repeat (3) @(negedge clk);
		chk({aoe, doe, iioe, iooe, wroe}, 5'h1f);
		chk(cyc, 0);
		chk(hold_req, 0);
		repeat (300) @(negedge clk);
		chk(ack, 1);
		apb(0, CPM_STATUS_ADDR, 0);
		chk(rd, 32'h0000_001b);
		pulse_finish;
		start <= 0;
		wait_ack(0, 8);
		chk(aoe, 1);
		repeat (4) @(negedge clk);
		chk({aoe, doe, iioe, iooe, wroe}, 5'h00);
	endtask

	// Hold in stopped state ended by an interrupt
	task t_hold_int;
		@(posedge clk) st <= CPM_ST_STOPPED; start <= 1;
		wait_ack(1, 600);
		@(posedge clk) int_req <= 1;
		repeat (4) @(posedge clk);
		pulse_psync;
		wait_ack(0, 6);
		chk(intl, 1);
		chk(wait_n, 0);
		pulse_finish;
		start <= 0;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1;
		t_regs;
		t_opts;
		t_flags;
		t_cycles;
		t_refuse;
		t_hold_wait;
		t_hold_int;
		conclude;
	end
endmodule
